//--- verilog/ofd_decoder.sv
// Purpose: Operand specifier decoder with an AXI4-Lite register window
// Assumes: Single clock; software loads fields and reads back decoded results
// Notes:   Decoded results trail a register write by one cycle
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ofd_defines.svh"
module ofd_decoder (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// AXI4-Lite write
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Decoded results to address and execution logic
	output ofd_pkg::ofd_word_t     ea_out,
	output ofd_pkg::ofd_seg_e      ea_seg,
	output logic [8:0]             flags_out,
	output logic [7:0]             extra_clocks
);
	import ofd_pkg::*;

	ofd_state_s s;
	ofd_state_s next_s;

	function automatic ofd_word_t ofd_merge(input ofd_word_t o, input ofd_word_t n,
		input logic [3:0] st);
		ofd_word_t r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Shared by both segment fields; the narrow one is zero-extended
	function automatic ofd_seg_e ofd_seg(input logic [2:0] code);
		unique case (code)
			3'h0: return ofd_seg_extra;
			3'h1: return ofd_seg_code;
			3'h2: return ofd_seg_stack;
			3'h3: return ofd_seg_data;
			3'h4: return ofd_seg_f;
			3'h5: return ofd_seg_g;
			default: return ofd_seg_bad;
		endcase
	endfunction

	// Returns valid flag above the register number
	function automatic logic [3:0] ofd_spec(input ofd_sp_e t, input logic [2:0] c);
		logic ok;
		ok = 1'b0;
		unique case (t)
			ofd_sp_ctrl:  ok = (c == 3'h0) || (c == 3'h2) || (c == 3'h3);
			ofd_sp_debug: ok = (c != 3'h4) && (c != 3'h5);
			ofd_sp_test:  ok = (c >= 3'h3);
			ofd_sp_none:  ok = 1'b0;
		endcase
		return {ok, ok ? c : 3'h0};
	endfunction

	// Penalty over an aligned 16-bit access on a no-wait bus
	function automatic logic [7:0] ofd_align(input logic [15:0] a);
		logic [1:0] sz;
		logic       both;
		logic       any;
		sz   = a[9:8];
		both = a[10] && a[11];
		any  = a[10] || a[11];
		if (!any) begin
			return 8'h00;
		end else if (sz == `OFD_SZ32 && a[12]) begin
			return both ? `OFD_CLK_ODD2 : `OFD_CLK_ODD1;
		end else if (sz == `OFD_SZ32 || (sz == `OFD_SZ16 && a[12])) begin
			return both ? `OFD_CLK_MIS2 : `OFD_CLK_MIS1;
		end
		return 8'h00;
	endfunction

	logic [1:0] f_ss;
	logic [2:0] f_idx;
	logic [2:0] f_base;
	logic [1:0] f_mod;
	logic       no_base;
	logic       no_idx;
	logic       wr_go;
	assign f_ss    = s.sib[`OFD_SS_HI:`OFD_SS_LO];
	assign f_idx   = s.sib[`OFD_IDX_HI:`OFD_IDX_LO];
	assign f_base  = s.sib[`OFD_BASE_HI:`OFD_BASE_LO];
	assign f_mod   = s.sib[`OFD_MOD_HI:`OFD_MOD_LO];
	assign no_base = (f_mod == `OFD_MOD_NONE) && (f_base == `OFD_R_BP);
	assign no_idx  = (f_idx == `OFD_NOIDX);
	assign wr_go   = s.aw_hold && s.w_hold && !s.bvalid;

	always_comb begin
		ofd_word_t  rd;
		ofd_word_t  term_base;
		ofd_word_t  term_idx;
		ofd_word_t  term_disp;
		ofd_seg_e   seg;
		logic       stk;
		logic       two;
		logic [7:0] ext;
		logic [3:0] spec;
		logic       hit;
		rd        = `OFD_ZERO32;
		term_base = `OFD_ZERO32;
		term_idx  = `OFD_ZERO32;
		term_disp = `OFD_ZERO32;
		seg       = ofd_seg_data;
		stk       = 1'b0;
		two       = 1'b0;
		ext       = 8'h00;
		spec      = 4'h0;
		hit       = 1'b1;
		next_s    = s;

		// Write address and data land in either order
		if (s.awready && s_axi_awvalid) begin
			next_s.aw_hold = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s.wready && s_axi_wvalid) begin
			next_s.w_hold = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (wr_go) begin
			next_s.aw_hold = 1'b0;
			next_s.w_hold  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = `OFD_RESP_OK;
			if (s.aw_addr[7:5] == `OFD_A_GPR_HI) begin
				next_s.gpr[s.aw_addr[4:2]] = ofd_merge(s.gpr[s.aw_addr[4:2]],
					s.w_data, s.w_strb);
			end else begin
				unique case (s.aw_addr)
					`OFD_A_SIB:    next_s.sib    = 10'(ofd_merge(32'(s.sib), s.w_data, s.w_strb));
					`OFD_A_DISP:   next_s.disp   = ofd_merge(s.disp, s.w_data, s.w_strb);
					`OFD_A_SEGSEL: next_s.segsel = 10'(ofd_merge(32'(s.segsel), s.w_data, s.w_strb));
					`OFD_A_FACT:   next_s.fact   = 18'(ofd_merge(32'(s.fact), s.w_data, s.w_strb));
					`OFD_A_ACCESS: next_s.access = 16'(ofd_merge(32'(s.access), s.w_data, s.w_strb));
					`OFD_A_FLAGS: begin
						// Whole word only: a result applies all nine actions at once
						for (int i = 0; i < `OFD_NFLAGS; i++) begin
							unique case (ofd_act_e'(s.fact[i*2 +: 2]))
								ofd_act_keep:   next_s.flags[i] = s.flags[i];
								ofd_act_modify: next_s.flags[i] = s.w_data[i];
								ofd_act_zero:   next_s.flags[i] = 1'b0;
								ofd_act_one:    next_s.flags[i] = 1'b1;
							endcase
						end
					end
					default: next_s.bresp = `OFD_RESP_ERR;
				endcase
			end
		end
		next_s.awready = !next_s.aw_hold && !next_s.bvalid;
		next_s.wready  = !next_s.w_hold && !next_s.bvalid;

		// Read port
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s.arready && s_axi_arvalid) begin
			if (s_axi_araddr[7:5] == `OFD_A_GPR_HI) begin
				rd = s.gpr[s_axi_araddr[4:2]];
			end else begin
				unique case (s_axi_araddr)
					`OFD_A_SIB:    rd = 32'(s.sib);
					`OFD_A_DISP:   rd = s.disp;
					`OFD_A_SEGSEL: rd = 32'(s.segsel);
					`OFD_A_FACT:   rd = 32'(s.fact);
					`OFD_A_FLAGS:  rd = 32'(s.flags);
					`OFD_A_ACCESS: rd = 32'(s.access);
					`OFD_A_EA:     rd = s.ea;
					`OFD_A_ADDRST: rd = 32'(s.addrst);
					`OFD_A_SEGST:  rd = 32'(s.segst);
					`OFD_A_TIMING: rd = 32'(s.timing);
					default:       hit = 1'b0;
				endcase
			end
			next_s.rvalid = 1'b1;
			next_s.rdata  = rd;
			next_s.rresp  = hit ? `OFD_RESP_OK : `OFD_RESP_ERR;
		end
		next_s.arready = !next_s.rvalid;

		// Effective address terms
		if (!no_base) begin
			term_base = s.gpr[f_base];
		end
		if (!no_idx) begin
			term_idx = s.gpr[f_idx] << f_ss;
		end
		unique case (f_mod)
			`OFD_MOD_NONE: term_disp = no_base ? s.disp : `OFD_ZERO32;
			`OFD_MOD_D8:   term_disp = {{24{s.disp[7]}}, s.disp[7:0]};
			`OFD_MOD_D32:  term_disp = s.disp;
			`OFD_MOD_REG:  term_disp = `OFD_ZERO32;
		endcase
		stk = (f_base == `OFD_R_SP) || ((f_base == `OFD_R_BP) && !no_base);
		seg = stk ? ofd_seg_stack : ofd_seg_data;
		two = !no_base && !no_idx;
		next_s.ea = term_base + term_idx + term_disp;
		next_s.addrst = {two, f_mod == `OFD_MOD_REG, no_idx && (f_ss != 2'h0),
			no_idx, no_base, no_base ? 3'h0 : f_base, seg};

		// Segment and special register selectors
		spec = ofd_spec(ofd_sp_e'(s.segsel[9:8]), s.segsel[7:5]);
		next_s.segst = {spec, s.segsel[4:3] == 2'h3,
			ofd_seg(s.segsel[4:2]), ofd_seg({1'b0, s.segsel[1:0]})};

		// Clock penalties
		ext = ofd_align(s.access) + (two ? `OFD_CLK_TWOREG : 8'h00);
		next_s.timing = {8'(s.access[7:0] + ext), ext};
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s         <= '0;
			s.awready <= 1'b1;
			s.wready  <= 1'b1;
			s.arready <= 1'b1;
			s.flags   <= `OFD_FLAGS_RST;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign s_axi_rvalid  = s.rvalid;
	assign ea_out        = s.ea;
	assign ea_seg        = ofd_seg_e'(s.addrst[2:0]);
	assign flags_out     = s.flags;
	assign extra_clocks  = s.timing[7:0];

	sequence q_flag_set;
		wr_go && s.aw_addr == `OFD_A_FLAGS && ofd_act_e'(s.fact[7:6]) == ofd_act_one;
	endsequence
	sequence q_flag_zero;
		wr_go && s.aw_addr == `OFD_A_FLAGS && ofd_act_e'(s.fact[5:4]) == ofd_act_zero;
	endsequence

	property p_no_base;
		@(posedge core_clk) disable iff (rst)
		no_base && f_mod == `OFD_MOD_NONE |=> s.addrst[6] && ea_seg == ofd_seg_data;
	endproperty
	a_no_base: assert property (p_no_base) else $error("no-base decode wrong");

	property p_stack;
		@(posedge core_clk) disable iff (rst)
		f_base == `OFD_R_BP && f_mod == `OFD_MOD_D8 |=> ea_seg == ofd_seg_stack;
	endproperty
	a_stack: assert property (p_stack) else $error("frame base not stack");

	property p_scale8;
		@(posedge core_clk) disable iff (rst)
		no_base && !no_idx && f_ss == 2'h3
		|=> ea_out == ($past(s.gpr[f_idx]) << 3) + $past(s.disp);
	endproperty
	a_scale8: assert property (p_scale8) else $error("scale by eight wrong");

	property p_no_idx;
		@(posedge core_clk) disable iff (rst)
		no_idx && no_base |=> ea_out == $past(s.disp);
	endproperty
	a_no_idx: assert property (p_no_idx) else $error("empty index added");

	property p_wide_bad;
		@(posedge core_clk) disable iff (rst)
		s.segsel[4:3] == 2'h3 |=> s.segst[6] && s.segst[5:3] == 3'h7;
	endproperty
	a_wide_bad: assert property (p_wide_bad) else $error("wide code not undefined");

	property p_ctrl_one;
		@(posedge core_clk) disable iff (rst)
		s.segsel[9:5] == 5'h01 |=> !s.segst[10];
	endproperty
	a_ctrl_one: assert property (p_ctrl_one) else $error("control code 001 valid");

	property p_flag_act;
		@(posedge core_clk) disable iff (rst)
		q_flag_set |=> flags_out[3];
	endproperty
	a_flag_act: assert property (p_flag_act) else $error("flag force wrong");

	property p_flag_zero;
		@(posedge core_clk) disable iff (rst)
		q_flag_zero |=> !flags_out[2];
	endproperty
	a_flag_zero: assert property (p_flag_zero) else $error("flag clear wrong");

	property p_odd32;
		@(posedge core_clk) disable iff (rst)
		s.access[12:8] == 5'h1E && !(!no_base && !no_idx) |=> extra_clocks == `OFD_CLK_ODD2;
	endproperty
	a_odd32: assert property (p_odd32) else $error("odd 32-bit penalty wrong");

	property p_two_reg;
		@(posedge core_clk) disable iff (rst)
		!no_base && !no_idx && s.access[11:10] == 2'h0 |=> extra_clocks == `OFD_CLK_TWOREG;
	endproperty
	a_two_reg: assert property (p_two_reg) else $error("two-register clock missing");
endmodule

//--- verilog/ofd_defines.svh
// Purpose: Offsets, field positions, reset values and counts for the operand field decoder
// Assumes: Byte addresses on an 8-bit AXI4-Lite address
// Notes:   Definitions only
`ifndef OFD_DEFINES_SVH
`define OFD_DEFINES_SVH
`define OFD_A_SIB      8'h00
`define OFD_A_DISP     8'h04
`define OFD_A_SEGSEL   8'h08
`define OFD_A_FACT     8'h0C
`define OFD_A_FLAGS    8'h10
`define OFD_A_ACCESS   8'h14
`define OFD_A_EA       8'h18
`define OFD_A_ADDRST   8'h1C
`define OFD_A_SEGST    8'h20
`define OFD_A_TIMING   8'h24
`define OFD_A_GPR_HI   3'h2
`define OFD_RESP_OK    2'h0
`define OFD_RESP_ERR   2'h2
`define OFD_SS_HI      7
`define OFD_SS_LO      6
`define OFD_IDX_HI     5
`define OFD_IDX_LO     3
`define OFD_BASE_HI    2
`define OFD_BASE_LO    0
`define OFD_MOD_HI     9
`define OFD_MOD_LO     8
`define OFD_NOIDX      3'h4
`define OFD_R_SP       3'h4
`define OFD_R_BP       3'h5
`define OFD_MOD_NONE   2'h0
`define OFD_MOD_D8     2'h1
`define OFD_MOD_D32    2'h2
`define OFD_MOD_REG    2'h3
`define OFD_SZ8        2'h0
`define OFD_SZ16       2'h1
`define OFD_SZ32       2'h2
`define OFD_CLK_TWOREG 8'h01
`define OFD_CLK_MIS1   8'h02
`define OFD_CLK_MIS2   8'h04
`define OFD_CLK_ODD1   8'h04
`define OFD_CLK_ODD2   8'h08
`define OFD_NFLAGS     9
`define OFD_FLAGS_RST  9'h000
`define OFD_ZERO32     32'h0000_0000
`endif

//--- verilog/ofd_pkg.sv
// Purpose: Types shared by the operand field decoder
// Assumes: Nothing beyond the defines header
// Notes:   Segment codes 0 to 5 follow the field encodings directly; 6 and 7 both give ofd_seg_bad
package ofd_pkg;
	typedef enum logic [2:0] {
		ofd_seg_extra = 3'h0,
		ofd_seg_code  = 3'h1,
		ofd_seg_stack = 3'h2,
		ofd_seg_data  = 3'h3,
		ofd_seg_f     = 3'h4,
		ofd_seg_g     = 3'h5,
		ofd_seg_bad   = 3'h7
	} ofd_seg_e;
	typedef enum logic [1:0] {
		ofd_act_keep   = 2'h0,
		ofd_act_modify = 2'h1,
		ofd_act_zero   = 2'h2,
		ofd_act_one    = 2'h3
	} ofd_act_e;
	typedef enum logic [1:0] {
		ofd_sp_ctrl  = 2'h0,
		ofd_sp_debug = 2'h1,
		ofd_sp_test  = 2'h2,
		ofd_sp_none  = 2'h3
	} ofd_sp_e;
	typedef logic [31:0] ofd_word_t;
	typedef struct packed {
		logic             awready;
		logic             wready;
		logic             arready;
		logic             aw_hold;
		logic [7:0]       aw_addr;
		logic             w_hold;
		ofd_word_t        w_data;
		logic [3:0]       w_strb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		ofd_word_t        rdata;
		logic [1:0]       rresp;
		logic [9:0]       sib;
		ofd_word_t        disp;
		logic [9:0]       segsel;
		logic [17:0]      fact;
		logic [8:0]       flags;
		logic [15:0]      access;
		ofd_word_t [7:0]  gpr;
		ofd_word_t        ea;
		logic [10:0]      addrst;
		logic [10:0]      segst;
		logic [15:0]      timing;
	} ofd_state_s;
endpackage

//--- testbench/ofd_sw_model.sv
// Purpose: Software-side AXI4-Lite master that loads and reads the decoder registers
// Assumes: One transfer at a time, started by a one-cycle go pulse
// Notes:   Released address and data lines are inverted so stale values are never trusted
`timescale 1ns/1ps
module ofd_sw_model (
	// Clock and reset
	input	wire logic		core_clk,
	input	wire logic		rst,
	// Command from the bench
	input	wire logic		go,
	input	wire logic		wr,
	input	wire logic [7:0]	addr,
	input	wire logic [31:0]	data,
	output	logic			done,
	output	logic [31:0]		rdata,
	output	logic [1:0]		resp,
	// AXI4-Lite master side
	output	logic [7:0]		awaddr,
	output	logic			awvalid,
	input	wire logic		awready,
	output	logic [31:0]		wdata,
	output	logic [3:0]		wstrb,
	output	logic			wvalid,
	input	wire logic		wready,
	input	wire logic [1:0]	bresp,
	input	wire logic		bvalid,
	output	logic			bready,
	output	logic [7:0]		araddr,
	output	logic			arvalid,
	input	wire logic		arready,
	input	wire logic [31:0]	s_rdata,
	input	wire logic [1:0]	rresp,
	input	wire logic		rvalid,
	output	logic			rready
);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{awvalid, wvalid, bready, arvalid, rready, done, awaddr, araddr, wdata} <= '0;
			{wstrb, rdata, resp} <= '0;
		end else begin
			done <= 1'b0;
			if (go && wr) begin
				{awaddr, wdata, wstrb} <= {addr, data, 4'hF};
				{awvalid, wvalid, bready} <= 3'h7;
			end
			if (go && !wr) begin
				araddr <= addr;
				{arvalid, rready} <= 2'h3;
			end
			// Each address and write-data channel is held until its own ready, then scrambled
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~awaddr;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~wdata;
			end
			if (bready && bvalid) begin
				{bready, done, resp} <= {2'h1, bresp};
			end
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~araddr;
			end
			if (rready && rvalid) begin
				{rready, done, resp, rdata} <= {2'h1, rresp, s_rdata};
			end
		end
	end
endmodule

//--- testbench/operand_field_decoder_bench.sv
// Purpose: Self-checking bench for the operand field decoder
// Assumes: Registers reached only through the software master model
// Notes:   Decoded outputs are sampled a few cycles after each write settles
`timescale 1ns/1ps
`include "ofd_defines.svh"
module operand_field_decoder_bench;
	import ofd_pkg::*;
	logic		core_clk, rst, go, wr, done, awvalid, awready, wvalid, wready;
	logic		bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0]	addr, awaddr, araddr, extra_clocks;
	logic [31:0]	data, rdata, wdata, s_rdata;
	logic [1:0]	resp, bresp, rresp;
	logic [3:0]	wstrb;
	logic [8:0]	flags_out;
	ofd_word_t	ea_out;
	ofd_seg_e	ea_seg;
	ofd_word_t	gv [8];
	int		n_errors = 0;
	int		checked = 0;

	ofd_sw_model i_ofd_sw_model (.core_clk(core_clk), .rst(rst), .go(go), .wr(wr),
		.addr(addr), .data(data), .done(done), .rdata(rdata), .resp(resp),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.s_rdata(s_rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	ofd_decoder i_ofd_decoder (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(s_rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ea_out(ea_out), .ea_seg(ea_seg), .flags_out(flags_out),
		.extra_clocks(extra_clocks));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		{go, wr, addr, data} <= {1'b1, w, a, d};
		@(posedge core_clk);
		go <= 1'b0;
		for (k = 0; k < 50 && done !== 1'b1; k++)
			@(posedge core_clk);
		if (done !== 1'b1) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		xfer(1'b1, a, d);
		chk("bresp", 32'(resp), 32'(er));
	endtask
	task automatic settle();
		repeat (3) @(posedge core_clk);
	endtask

	task automatic t_reset();
		chk("ea rst", ea_out, 32'h0);
		chk("flags rst", 32'(flags_out), 32'h0);
		chk("extra rst", 32'(extra_clocks), 32'h0);
		xfer(1'b0, `OFD_A_FLAGS, 32'h0);
		chk("flags reg rst", rdata, 32'h0);
	endtask
	task automatic t_ea();
		int m, b, s, x;
		ofd_word_t e, dsp;
		logic nb, ni;
		logic [2:0] sg;
		for (b = 0; b < 8; b++) begin
			gv[b] = 32'h0000_0100 * (b + 1);
			wreg(8'h40 + 8'(4 * b), gv[b], `OFD_RESP_OK);
		end
		wreg(`OFD_A_DISP, 32'h1234_5680, `OFD_RESP_OK);
		for (m = 0; m < 3; m++) for (b = 0; b < 8; b++) begin
			x = (b + 3) % 8;
			s = (x == 4) ? 0 : b % 4;
			wreg(`OFD_A_SIB, {22'h0, 2'(m), 2'(s), 3'(x), 3'(b)}, `OFD_RESP_OK);
			settle();
			// Short displacement is the low byte sign-extended
			dsp = (m == 1) ? 32'hFFFF_FF80 : (m == 2 || b == 5) ? 32'h1234_5680 : 32'h0;
			nb = (m == 0 && b == 5);
			ni = (x == 4);
			sg = (b == 4 || (b == 5 && m != 0)) ? 3'h2 : 3'h3;
			e = (nb ? 32'h0 : gv[b]) + (ni ? 32'h0 : gv[x] << s) + dsp;
			chk("ea", ea_out, e);
			chk("seg", 32'(ea_seg), 32'(sg));
			xfer(1'b0, `OFD_A_ADDRST, 32'h0);
			chk("addrst", rdata, 32'({!nb && !ni, 2'h0, ni, nb, nb ? 3'h0 : 3'(b), sg}));
		end
	endtask
	task automatic t_seg();
		int t, c, v;
		for (t = 0; t < 4; t++) for (c = 0; c < 8; c++) begin
			wreg(`OFD_A_SEGSEL, {22'h0, 2'(t), 3'(c), 3'(c), 2'(c)}, `OFD_RESP_OK);
			v = (t == 0) ? (c == 0 || c == 2 || c == 3) : (t == 1) ? (c < 4 || c > 5) :
				(t == 2) ? (c > 2) : 0;
			xfer(1'b0, `OFD_A_SEGST, 32'h0);
			chk("narrow", 32'(rdata[2:0]), 32'(c % 4));
			chk("wide", 32'(rdata[6:3]), (c > 5) ? 32'hF : 32'(c));
			chk("valid", 32'(rdata[10]), 32'(v));
			if (v != 0)
				chk("num", 32'(rdata[9:7]), 32'(c));
		end
	endtask
	task automatic t_flags();
		int i;
		logic [31:0] f;
		logic [8:0] r, ex;
		wreg(`OFD_A_FACT, 32'h0001_5555, `OFD_RESP_OK);
		wreg(`OFD_A_FLAGS, 32'h0000_00F0, `OFD_RESP_OK);
		settle();
		chk("flags mod", 32'(flags_out), 32'h0F0);
		f = 32'h0;
		r = 9'h10F;
		for (i = 0; i < 9; i++) begin
			f[2 * i +: 2] = 2'(i % 4);
			ex[i] = (i % 4 == 0) ? (i == 4) : (i % 4 == 1) ? r[i] : (i % 4 == 3);
		end
		wreg(`OFD_A_FACT, f, `OFD_RESP_OK);
		wreg(`OFD_A_FLAGS, 32'(r), `OFD_RESP_OK);
		settle();
		chk("flags mix", 32'(flags_out), 32'(ex));
		xfer(1'b0, `OFD_A_FLAGS, 32'h0);
		chk("flags reg", rdata, 32'(ex));
	endtask
	task automatic t_timing();
		int z, k, o, n, p;
		wreg(`OFD_A_SIB, 32'h0000_0025, `OFD_RESP_OK);
		for (z = 0; z < 3; z++) for (k = 1; k < 4; k++) for (o = 0; o < 2; o++) begin
			n = (k & 1) + (k >> 1);
			p = (z == 2 && o == 1) ? 4 * n : (z == 2 || (z == 1 && o == 1)) ? 2 * n : 0;
			wreg(`OFD_A_ACCESS, {19'h0, 1'(o), 2'(k), 2'(z), 8'h05}, `OFD_RESP_OK);
			settle();
			chk("extra", 32'(extra_clocks), 32'(p));
			xfer(1'b0, `OFD_A_TIMING, 32'h0);
			chk("timing", rdata, 32'({8'(5 + p), 8'(p)}));
		end
		// Index, scale and displacement alone, then base plus index
		wreg(`OFD_A_ACCESS, 32'h0000_0505, `OFD_RESP_OK);
		wreg(`OFD_A_SIB, 32'h0000_00CD, `OFD_RESP_OK);
		settle();
		chk("one reg", 32'(extra_clocks), 32'h0);
		wreg(`OFD_A_SIB, 32'h0000_0008, `OFD_RESP_OK);
		settle();
		chk("two reg", 32'(extra_clocks), 32'h1);
	endtask
	task automatic t_bus();
		wreg(`OFD_A_EA, 32'h0000_0001, `OFD_RESP_ERR);
		wreg(8'h60, 32'h0000_0001, `OFD_RESP_ERR);
		xfer(1'b0, 8'h30, 32'h0);
		chk("rresp", 32'(resp), 32'(`OFD_RESP_ERR));
		xfer(1'b0, 8'h44, 32'h0);
		chk("gpr", rdata, gv[1]);
		// Register form: base only, no displacement, no index, scale kept at 00
		wreg(`OFD_A_SIB, 32'h0000_0320, `OFD_RESP_OK);
		settle();
		chk("ea mod3", ea_out, gv[0]);
		xfer(1'b0, `OFD_A_ADDRST, 32'h0);
		chk("addrst mod3", rdata, 32'h0000_0283);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		{rst, go, wr, addr, data} = {1'b1, 42'h0};
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_ea();
		t_seg();
		t_flags();
		t_timing();
		t_bus();
		report_and_stop();
	end
endmodule
